// [design/servo_io_defines.svh]
// register offsets, field positions and reset values of the servo control i/o block
// included by the package users; definitions only
`ifndef SERVO_IO_DEFINES_SVH
`define SERVO_IO_DEFINES_SVH

`define OFS_SETUP_ONE 8'h00
`define OFS_SETUP_TWO 8'h04
`define OFS_INPOS_WIN 8'h08
`define OFS_DEVIATION 8'h0C
`define OFS_STATUS 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18

`define S1_RUN_BYPASS 0
`define S1_FWD_BYPASS 2
`define S1_REV_BYPASS 3
`define S2_MODE_LO 3
`define S2_MODE_HI 5
`define S2_CLR_EDGE 10

`define PM_STEP_DIR 3'h0
`define PM_REV_FWD 3'h1
`define PM_QUAD 3'h2

`define RST_SETUP_ONE 16'h0000
`define RST_SETUP_TWO 16'h0000
`define RST_INPOS_WIN 16'h000A

`define IRQ_ALARM 0
`define IRQ_INPOS 1
`define IRQ_CLEAR 2
`define IRQ_LIMIT 3
`define IRQ_W 4

`endif

// [design/servo_io_pkg.sv]
// types shared by the servo control i/o block and its decoder
// no surroundings assumed
package servo_io_pkg;
  typedef logic [2:0] pulse_mode_t;
  typedef logic [15:0] setup_word_t;
  typedef struct packed {
    logic step;
    logic fwd;
  } step_t;
endpackage

// [design/io_sync.sv]
// two-flop synchroniser for a group of unrelated level inputs
// assumes inputs are asynchronous to pclk
`timescale 1ns/1ps
module io_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// [design/pulse_decoder.sv]
// decodes a synchronised a/b pulse pair into one step event with a direction
// assumes a and b are already on pclk; rates far below pclk
`timescale 1ns/1ps
`include "servo_io_defines.svh"
module pulse_decoder import servo_io_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire pulse_mode_t mode,
  input wire logic a,
  input wire logic b,
  output step_t ev
);
  logic a_q;
  logic b_q;
  wire rise_a = a & ~a_q;
  wire rise_b = b & ~b_q;
  // one edge of either phase per sample; a leading b counts forward
  wire quad_step = (a ^ a_q) ^ (b ^ b_q);
  wire quad_fwd = ~(a_q ^ b);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= a;
      b_q <= b;
    end
  end

  always_comb begin
    ev = '0;
    case (mode)
      `PM_STEP_DIR: begin
        ev.step = rise_a;
        ev.fwd = b;
      end
      `PM_REV_FWD: begin
        // simultaneous edges cancel
        ev.step = rise_a ^ rise_b;
        ev.fwd = rise_b;
      end
      `PM_QUAD: begin
        ev.step = quad_step;
        ev.fwd = quad_fwd;
      end
      default: begin
        ev = '0;
      end
    endcase
  end
endmodule

// [design/servo_io_ctrl.sv]
// control i/o logic of a pulse-train servo drive: command decoding, deviation
// counter, sequence inputs and outputs, apb register file with interrupt
// assumes apb master on pclk; all pin inputs asynchronous; fault_cond from pclk logic
//
// What this block does
// R01: decode step/dir, rev/fwd, or quadrature per setup
// R02: accept command pulses up to 200 kpps
// R03: clear input ignores pulses, zeroes deviation
// R04: setup bit picks level or edge clear
// R05: run input enables power unless bypassed
// R06: gain reduce input lowers speed gain
// R07: forward limit active low, bypassable
// R08: reverse limit active low, bypassable
// R09: alarm reset input clears latched alarm
// R10: in-position when deviation within window
// R11: index output off while index detected
// R12: fault output on normally, off on alarm
// R13: brake interlock output follows servo on
// R14: controller holds clear at least 20 us
// R15: limit stop raises no alarm
// R16: command pulses use positive logic
// R17: deviation adds commands, subtracts feedback
// R18: all control inputs synchronised first
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "servo_io_defines.svh"
module servo_io_ctrl import servo_io_pkg::*; #(
  parameter int DEV_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic feed_step,
  input wire logic forward_pulse_in,
  input wire logic error_counter_clear,
  input wire logic run_in,
  input wire logic gain_lower_in,
  input wire logic forward_limit_in,
  input wire logic reverse_limit_in,
  input wire logic alarm_reset_in,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  input wire logic enc_index_in,
  input wire logic fault_cond,
  output logic in_position_done,
  output logic brake_interlock_out,
  output logic fault_out,
  output logic index_out,
  output logic power_enable,
  output logic gain_low,
  output logic fwd_blocked,
  output logic rev_blocked,
  output logic irq
);
  if (DEV_W < 8 || DEV_W > 30) begin : g_bad_width
    $error("DEV_W must lie in 8..30");
  end
  if (`RST_INPOS_WIN >= (1 << (DEV_W - 1))) begin : g_bad_window
    $error("reset window exceeds the deviation range");
  end

  localparam logic signed [DEV_W+1:0] DEV_MAX = (DEV_W+2)'((1 <<< (DEV_W-1)) - 1);

  function automatic logic [DEV_W-1:0] mag(input logic signed [DEV_W-1:0] v);
    mag = v[DEV_W-1] ? DEV_W'(-v) : DEV_W'(v);
  endfunction

  // signed unit step of a decoded event; zero when not taken
  function automatic logic signed [DEV_W+1:0] step_delta(input step_t e, input logic take);
    if (!take) begin
      return '0;
    end
    return e.fwd ? (DEV_W+2)'(1) : (DEV_W+2)'(-1);
  endfunction

  // one register per aligned word of the map
  function automatic logic at_ofs(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // synchronised pins [R18]
  logic [10:0] pins;
  io_sync #(.W(11)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    // limits enter inverted so the reset value of 0 means no stop
    .d({enc_index_in, enc_b_in, enc_a_in, alarm_reset_in, ~reverse_limit_in,
        ~forward_limit_in, gain_lower_in, run_in, error_counter_clear,
        forward_pulse_in, feed_step}),
    .q(pins)
  );
  wire s_a = pins[0];
  wire s_b = pins[1];
  wire s_clr = pins[2];
  wire s_run = pins[3];
  wire s_gain = pins[4];
  wire s_fwd_stop = pins[5];
  wire s_rev_stop = pins[6];
  wire s_arst = pins[7];
  wire s_ea = pins[8];
  wire s_eb = pins[9];
  wire s_idx = pins[10];

  setup_word_t setup_one_reg;
  setup_word_t setup_two_reg;
  logic [DEV_W-1:0] win_reg;
  logic signed [DEV_W-1:0] dev_reg;
  logic alarm_reg;
  logic clr_q;
  logic arst_q;
  logic inpos_q;
  logic block_q;
  logic [`IRQ_W-1:0] irq_stat_reg;
  logic [`IRQ_W-1:0] irq_mask_reg;

  // command and feedback decoders [R01] [R16]
  step_t cmd_ev;
  step_t enc_ev;
  pulse_decoder u_cmd (
    .pclk(pclk),
    .presetn(presetn),
    .mode(setup_two_reg[`S2_MODE_HI:`S2_MODE_LO]),
    .a(s_a),
    .b(s_b),
    .ev(cmd_ev)
  );
  pulse_decoder u_enc (
    .pclk(pclk),
    .presetn(presetn),
    .mode(`PM_QUAD),
    .a(s_ea),
    .b(s_eb),
    .ev(enc_ev)
  );

  // apb decode
  wire apb_access = psel & penable;
  // writes land only in the ready cycle
  wire wr_en = apb_access & pwrite & pready;
  wire hit_s1 = at_ofs(paddr, `OFS_SETUP_ONE);
  wire hit_s2 = at_ofs(paddr, `OFS_SETUP_TWO);
  wire hit_win = at_ofs(paddr, `OFS_INPOS_WIN);
  wire hit_dev = at_ofs(paddr, `OFS_DEVIATION);
  wire hit_st = at_ofs(paddr, `OFS_STATUS);
  wire hit_is = at_ofs(paddr, `OFS_IRQ_STATUS);
  wire hit_im = at_ofs(paddr, `OFS_IRQ_MASK);
  wire mapped = hit_s1 | hit_s2 | hit_win | hit_dev | hit_st | hit_is | hit_im;

  // limits, active low, bypassable; stopping here never alarms [R07] [R08] [R15]
  wire fwd_blk = ~setup_one_reg[`S1_FWD_BYPASS] & s_fwd_stop;
  wire rev_blk = ~setup_one_reg[`S1_REV_BYPASS] & s_rev_stop;

  // clear: level or rising edge [R03] [R04]
  wire clr_edge_mode = setup_two_reg[`S2_CLR_EDGE];
  wire clr_rise = s_clr & ~clr_q;
  wire clr_act = clr_edge_mode ? clr_rise : s_clr;

  // accepted command step; one per cycle covers 200 kpps easily [R02]
  wire cmd_ok = cmd_ev.step & ~clr_act & ~(cmd_ev.fwd ? fwd_blk : rev_blk);
  wire signed [DEV_W+1:0] cmd_d = step_delta(cmd_ev, cmd_ok);
  wire signed [DEV_W+1:0] enc_d = step_delta(enc_ev, enc_ev.step);
  // deviation = commands minus feedback [R17]
  wire signed [DEV_W+1:0] dev_sum = (DEV_W+2)'(dev_reg) + cmd_d - enc_d;
  wire dev_hi = dev_sum > DEV_MAX;
  wire dev_lo = dev_sum < -DEV_MAX;
  wire dev_ovf = dev_hi | dev_lo;

  logic signed [DEV_W-1:0] dev_next;
  always_comb begin
    if (clr_act) begin
      dev_next = '0; // [R03]
    end else if (dev_hi) begin
      dev_next = DEV_MAX[DEV_W-1:0];
    end else if (dev_lo) begin
      dev_next = DEV_W'(-DEV_MAX);
    end else begin
      dev_next = dev_sum[DEV_W-1:0];
    end
  end

  // alarm latch: a new cause wins over reset [R09]
  wire alarm_set = fault_cond | (dev_ovf & ~clr_act);
  wire arst_rise = s_arst & ~arst_q;
  wire alarm_next = alarm_set | (alarm_reg & ~arst_rise);

  // servo on [R05]
  wire servo_on = (setup_one_reg[`S1_RUN_BYPASS] | s_run) & ~alarm_next;
  // in-position [R10]
  wire inpos_next = mag(dev_next) <= win_reg;
  // any engaged limit, for the interrupt edge
  wire blk_now = fwd_blk | rev_blk;

  wire [`IRQ_W-1:0] irq_ev;
  assign irq_ev[`IRQ_ALARM] = alarm_set & ~alarm_reg;
  assign irq_ev[`IRQ_INPOS] = inpos_next & ~inpos_q;
  assign irq_ev[`IRQ_CLEAR] = clr_act;
  assign irq_ev[`IRQ_LIMIT] = blk_now & ~block_q;
  // an event wins over a write-one clear in the same cycle
  wire [`IRQ_W-1:0] w1c = (wr_en & hit_is) ? pwdata[`IRQ_W-1:0] : '0;
  wire [`IRQ_W-1:0] irq_stat_next = irq_ev | (irq_stat_reg & ~w1c);

  wire [31:0] status_word = {24'h000000, alarm_reg, inpos_q, rev_blk, fwd_blk,
                             s_gain, s_clr, servo_on, s_run};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_s1) begin
      rd_mux = {16'h0000, setup_one_reg};
    end else if (hit_s2) begin
      rd_mux = {16'h0000, setup_two_reg};
    end else if (hit_win) begin
      rd_mux = 32'(win_reg);
    end else if (hit_dev) begin
      rd_mux = 32'(signed'(dev_reg));
    end else if (hit_st) begin
      rd_mux = status_word;
    end else if (hit_is) begin
      rd_mux = 32'(irq_stat_reg);
    end else if (hit_im) begin
      rd_mux = 32'(irq_mask_reg);
    end
  end

  // apb slave: one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_access & ~pready;
      pslverr <= apb_access & ~pready & ~mapped;
      prdata <= (apb_access & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_one_reg <= `RST_SETUP_ONE;
      setup_two_reg <= `RST_SETUP_TWO;
      win_reg <= DEV_W'(`RST_INPOS_WIN);
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      if (hit_s1) setup_one_reg <= pwdata[15:0];
      if (hit_s2) setup_two_reg <= pwdata[15:0];
      if (hit_win) win_reg <= pwdata[DEV_W-1:0];
      if (hit_im) irq_mask_reg <= pwdata[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_reg <= '0;
      alarm_reg <= 1'b0;
      clr_q <= 1'b0;
      arst_q <= 1'b0;
      inpos_q <= 1'b0;
      block_q <= 1'b0;
      irq_stat_reg <= '0;
    end else begin
      dev_reg <= dev_next; // [R17]
      alarm_reg <= alarm_next; // [R09]
      clr_q <= s_clr;
      arst_q <= s_arst;
      inpos_q <= inpos_next;
      block_q <= blk_now;
      irq_stat_reg <= irq_stat_next;
    end
  end

  // registered pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_position_done <= 1'b0;
      brake_interlock_out <= 1'b0;
      fault_out <= 1'b0;
      index_out <= 1'b1;
      power_enable <= 1'b0;
      gain_low <= 1'b0;
      fwd_blocked <= 1'b0;
      rev_blocked <= 1'b0;
      irq <= 1'b0;
    end else begin
      in_position_done <= inpos_next; // [R10]
      brake_interlock_out <= servo_on; // [R13]
      fault_out <= ~alarm_next; // [R12]
      index_out <= ~s_idx; // [R11]
      power_enable <= servo_on; // [R05]
      gain_low <= s_gain; // [R06]
      fwd_blocked <= fwd_blk; // [R07]
      rev_blocked <= rev_blk; // [R08]
      // level request from sticky status and mask
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end
endmodule

// [sim/servo_io_ctrl_properties.sv]
// port-level checks of the servo control i/o block
// bound to every servo_io_ctrl instance; one clock domain
`timescale 1ns/1ps
module servo_io_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic gain_lower_in,
  input wire logic enc_index_in,
  input wire logic forward_limit_in,
  input wire logic reverse_limit_in,
  input wire logic fault_cond,
  input wire logic gain_low,
  input wire logic index_out,
  input wire logic fwd_blocked,
  input wire logic rev_blocked,
  input wire logic fault_out,
  input wire logic power_enable,
  input wire logic brake_interlock_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  AST_GAIN: assert property (gain_low == $past(gain_lower_in, 3))
    else $error("gain_low wrong");
  AST_INDEX: assert property (index_out == !$past(enc_index_in, 3))
    else $error("index_out wrong");
  AST_FWD: assert property (fwd_blocked |-> !$past(forward_limit_in, 3))
    else $error("fwd_blocked without limit");
  AST_REV: assert property (rev_blocked |-> !$past(reverse_limit_in, 3))
    else $error("rev_blocked without limit");
  AST_FAULT: assert property (fault_cond |-> ##[1:3] !fault_out)
    else $error("fault_out stayed on");
  AST_BRAKE: assert property (brake_interlock_out == power_enable)
    else $error("brake interlock wrong");
  AST_ALARM_OFF: assert property (!fault_out |-> !power_enable)
    else $error("power on during alarm");
  cover property (pslverr);
  cover property ($fell(fault_out));
  cover property (fwd_blocked && rev_blocked);
endmodule
bind servo_io_ctrl servo_io_ctrl_properties servo_io_ctrl_properties_i(.*);

// [sim/host_ctrl_model.sv]
// host controller model: drives command pulses in the chosen format
// assumes the caller sets the same mode in the drive
`timescale 1ns/1ps
module host_ctrl_model #(
  parameter int HALF = 250
) (
  input wire logic pclk,
  output logic feed_step,
  output logic forward_pulse_in
);
  logic [1:0] ph = 2'h0;
  initial begin
    feed_step = 1'b0;
    forward_pulse_in = 1'b0;
  end
  // each level held half of a 200 kpps period, active high
  task automatic hold(input logic a, input logic b);
    @(posedge pclk);
    feed_step <= a;
    forward_pulse_in <= b;
    repeat (HALF - 1) @(posedge pclk);
  endtask
  task automatic send(input logic [2:0] mode, input int n, input logic fwd);
    for (int i = 0; i < n; i++) begin
      if (mode == 3'h2) begin
        ph = fwd ? ph + 2'h1 : ph - 2'h1;
        hold(ph[1] ^ ph[0], ph[1]);
      end else if (mode == 3'h1) begin
        hold(!fwd, fwd);
        hold(1'b0, 1'b0);
      end else begin
        hold(1'b0, fwd);
        hold(1'b1, fwd);
        hold(1'b0, 1'b0);
      end
    end
  endtask
endmodule

// [sim/servo_io_ctrl_tb.sv]
// self-checking bench of the servo control i/o block
// host model drives pulses; bench drives apb and sequence pins
`timescale 1ns/1ps
module servo_io_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic feed_step, forward_pulse_in, error_counter_clear, run_in, gain_lower_in;
  logic forward_limit_in, reverse_limit_in, alarm_reset_in, enc_index_in, fault_cond;
  logic enc_a_in, enc_b_in;
  logic in_position_done, brake_interlock_out, fault_out, index_out, power_enable;
  logic gain_low, fwd_blocked, rev_blocked, irq;
  int err_total, check_count, n, w, k;
  servo_io_ctrl servo_io_ctrl_i(.*);
  host_ctrl_model host_ctrl_model_i(.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] servo_exp(input int b);
    return (b[0] | b[1]) ? 32'h3 : 32'h0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      err_total++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (5) @(posedge pclk);
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    results();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {error_counter_clear, run_in, gain_lower_in, alarm_reset_in} = '0;
    {enc_a_in, enc_b_in, enc_index_in, fault_cond, presetn} = '0;
    {forward_limit_in, reverse_limit_in} = 2'h3;
    {err_total, check_count} = '0;
    void'($urandom(61356));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'hA);
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(er), 32'h1);
    for (int b = 0; b < 4; b++) begin
      run_in <= b[1];
      apb(1'b1, 8'h00, 32'(b[0]));
      settle();
      chk(32'({power_enable, brake_interlock_out}), servo_exp(b));
    end
    repeat (4) begin
      {gain_lower_in, enc_index_in} <= 2'($urandom);
      settle();
      chk(32'({gain_low, index_out}), 32'({gain_lower_in, !enc_index_in}));
    end
    for (int m = 0; m < 3; m++) begin
      w = $urandom_range(1, 6);
      n = $urandom_range(1, 2) * 4;
      apb(1'b1, 8'h04, 32'(m << 3));
      apb(1'b1, 8'h08, 32'(w));
      host_ctrl_model_i.send(3'(m), n, 1'b1);
      settle();
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'(n));
      chk(32'(in_position_done), 32'(n <= w));
      error_counter_clear <= 1'b1; // held past the 20 us minimum
      host_ctrl_model_i.send(3'(m), 4, 1'b1);
      repeat (2000) @(posedge pclk);
      error_counter_clear <= 1'b0;
      settle();
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0);
    end
    {forward_limit_in, reverse_limit_in} <= 2'h0;
    settle();
    chk(32'({fwd_blocked, rev_blocked, fault_out}), 32'h7);
    host_ctrl_model_i.send(3'h2, 4, 1'b1);
    apb(1'b1, 8'h00, 32'h9);
    host_ctrl_model_i.send(3'h2, 4, 1'b0);
    settle();
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'hFFFFFFFC);
    chk(32'({fwd_blocked, rev_blocked}), 32'h2);
    k = $urandom_range(1, 7);
    for (int i = 1; i <= k; i++) begin
      {enc_a_in, enc_b_in} <= {i[1] ^ i[0], i[1]};
      repeat (4) @(posedge pclk);
    end
    settle();
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'(-4 - k));
    apb(1'b1, 8'h04, 32'h410);
    error_counter_clear <= 1'b1;
    settle();
    host_ctrl_model_i.send(3'h2, 4, 1'b0);
    settle();
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'hFFFFFFFC);
    error_counter_clear <= 1'b0;
    apb(1'b1, 8'h18, 32'h1);
    fault_cond <= 1'b1;
    @(posedge pclk);
    fault_cond <= 1'b0;
    settle();
    chk(32'({fault_out, irq, power_enable}), 32'h2);
    alarm_reset_in <= 1'b1;
    settle();
    apb(1'b1, 8'h14, 32'hF);
    settle();
    chk(32'({fault_out, irq, power_enable}), 32'h5);
    results();
  end
endmodule
